// [verilog/tpwm_core.sv]
// 16-bit pwm timer with clock gate, clear select, compare buffer and wishbone slave
// How it works
// - gate bit low: timer held in reset and its register writes ignored
// - gate bit high: timer clocked, registers readable and writable
// - run bit starts counting; clearing it stops and, in pwm mode, restores pwm initial level
// - mask bit high blocks the interrupt output, low lets it through
// - pending flag is set by a timer event, cleared by writing 0
// - clear select: none, match a, match b, reserved
// - source select: clock divided 1,2,4,8,32, external a or b; 6 reserved
// - compare registers a and b are 16 bits, meaning set by mode
// - in pwm mode a sets the period, b the level change point
// - pwm pin goes high on match a and low on match b
// - mode bit 0 selects pwm mode when 1, plain timer when 0
// - with buffering on, buffer b loads compare b at each match b
// - phase select 0: counter counts the selected count source
`timescale 1ns/1ps
`default_nettype none
module tpwm_core (
  input wire logic clk_i,                               // 25 MHz system clock
  input wire logic rst_i,                               // sync reset, high
  input wire logic wb_cyc_i,                            // wishbone cycle
  input wire logic wb_stb_i,                            // wishbone strobe
  input wire logic wb_we_i,                             // wishbone write
  input wire logic [tpwm_pkg::ADDR_W-1:0] wb_adr_i,     // byte address
  input wire logic [3:0] wb_sel_i,                      // byte lanes
  input wire logic [tpwm_pkg::DATA_W-1:0] wb_dat_i,     // write data
  output logic [tpwm_pkg::DATA_W-1:0] wb_dat_o,         // read data, registered
  output logic wb_ack_o,                                // acknowledge, registered
  input wire logic ext_clock_a_i,                       // external count clock a
  input wire logic ext_clock_b_i,                       // external count clock b
  output logic pwm_out_pin_o,                           // pwm output, registered
  output logic timer_irq_o                              // masked timer request
);
  import tpwm_pkg::*;

  logic ack_q, ack_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;
  logic timer_clock_gate_q, timer_clock_gate_d;
  logic count_run_q, count_run_d;
  logic phase_count_select_q, phase_count_select_d;
  logic pwm_mode_select_q, pwm_mode_select_d;
  logic timer_irq_mask_q, timer_irq_mask_d;
  logic timer_irq_pending_q, timer_irq_pending_d;
  tpwm_clr_t clear_select_q, clear_select_d;
  logic [2:0] source_select_q, source_select_d;
  logic buffer_b_enable_q, buffer_b_enable_d;
  logic [CNT_W-1:0] compare_a_q, compare_a_d;
  logic [CNT_W-1:0] compare_b_q, compare_b_d;
  logic [CNT_W-1:0] buffer_b_q, buffer_b_d;
  logic [CNT_W-1:0] main_counter_q, main_counter_d;
  logic pwm_q, pwm_d;
  logic timer_rst;
  logic tick;
  logic step;
  logic match_a;
  logic match_b;
  logic wr;
  logic wr_lo;
  logic wr_hi;
  logic timer_wr;

  // merge a 16-bit register with the enabled write lanes
  function automatic logic [CNT_W-1:0] lane16(input logic [CNT_W-1:0] old, input logic [DATA_W-1:0] d,
                                             input logic [3:0] sel);
    logic [CNT_W-1:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // gate low holds the whole timer in reset
  assign timer_rst = rst_i | ~timer_clock_gate_q;

  tpwm_prescale u_prescale (
    .clk_i(clk_i),
    .rst_i(timer_rst),
    .src_sel_i(source_select_q),
    .ext_clock_a_i(ext_clock_a_i),
    .ext_clock_b_i(ext_clock_b_i),
    .tick_o(tick)
  );

  // writes land on the edge that carries the ack, as the master samples it
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign wr_lo = wr & wb_sel_i[0];
  assign wr_hi = wr & wb_sel_i[1];
  // timer registers refuse writes while the gate is low
  assign timer_wr = timer_clock_gate_q;

  // phase counting is not built; with it selected the counter holds
  assign step = count_run_q & tick & ~phase_count_select_q;
  assign match_a = step & (main_counter_q == compare_a_q);
  assign match_b = step & (main_counter_q == compare_b_q);

  // bus answer: ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d = rdat_q;
    if (ack_d) begin
      rdat_d = '0;
      unique case (wb_adr_i)
        OFF_GATE: rdat_d[GATE_BIT] = timer_clock_gate_q;
        OFF_MODE: begin
          rdat_d[RUN_BIT] = count_run_q;
          rdat_d[PHASE_BIT] = phase_count_select_q;
          rdat_d[PWM_BIT] = pwm_mode_select_q;
        end
        OFF_MASK: rdat_d[MASK_BIT] = timer_irq_mask_q;
        OFF_REQ: rdat_d[PEND_BIT] = timer_irq_pending_q;
        OFF_CNTCTL: begin
          rdat_d[CLR_HI:CLR_LO] = clear_select_q;
          rdat_d[SRC_HI:SRC_LO] = source_select_q;
        end
        OFF_CMPA: rdat_d[CNT_W-1:0] = compare_a_q;
        OFF_CMPB: rdat_d[CNT_W-1:0] = compare_b_q;
        OFF_BUFB: rdat_d[CNT_W-1:0] = buffer_b_q;
        OFF_IOCTL: rdat_d[BUFB_BIT] = buffer_b_enable_q;
        OFF_COUNT: rdat_d[CNT_W-1:0] = main_counter_q;
        default: rdat_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // gate and interrupt controller bits live outside the gated timer
  always_comb begin
    timer_clock_gate_d = timer_clock_gate_q;
    timer_irq_mask_d = timer_irq_mask_q;
    timer_irq_pending_d = timer_irq_pending_q;
    // gate bit enables clock and access
    if (wr_lo && wb_adr_i == OFF_GATE) begin
      timer_clock_gate_d = wb_dat_i[GATE_BIT];
    end
    if (wr_lo && wb_adr_i == OFF_MASK) begin
      timer_irq_mask_d = wb_dat_i[MASK_BIT];
    end
    // write 0 clears; a same-cycle event still sets it
    if (wr_lo && wb_adr_i == OFF_REQ && !wb_dat_i[PEND_BIT]) begin
      timer_irq_pending_d = 1'b0;
    end
    if (match_a) begin
      timer_irq_pending_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_clock_gate_q <= 1'b0;
      timer_irq_mask_q <= MASK_RST;
      timer_irq_pending_q <= 1'b0;
    end else begin
      timer_clock_gate_q <= timer_clock_gate_d;
      timer_irq_mask_q <= timer_irq_mask_d;
      timer_irq_pending_q <= timer_irq_pending_d;
    end
  end

  // mask gates the request onto the output
  assign timer_irq_o = timer_irq_pending_q & ~timer_irq_mask_q;

  // timer registers, counter and pwm level
  always_comb begin
    count_run_d = count_run_q;
    phase_count_select_d = phase_count_select_q;
    pwm_mode_select_d = pwm_mode_select_q;
    clear_select_d = clear_select_q;
    source_select_d = source_select_q;
    buffer_b_enable_d = buffer_b_enable_q;
    compare_a_d = compare_a_q;
    compare_b_d = compare_b_q;
    buffer_b_d = buffer_b_q;
    main_counter_d = main_counter_q;
    pwm_d = pwm_q;
    // step once per tick, restart after the chosen clear match
    if (step) begin
      main_counter_d = main_counter_q + 16'h0001;
    end
    // clear source select; the reserved code clears nothing
    unique case (clear_select_q)
      TPWM_CLR_A: if (match_a) main_counter_d = CNT_RST;
      TPWM_CLR_B: if (match_b) main_counter_d = CNT_RST;
      TPWM_CLR_NONE, TPWM_CLR_RSVD: ;
    endcase
    // buffered compare b reload at match b
    if (buffer_b_enable_q && match_b) begin
      compare_b_d = buffer_b_q;
    end
    // a marks the period start, b the change point
    // high on match a, low on match b; b wins if both hit
    if (pwm_mode_select_q) begin
      if (match_a) begin
        pwm_d = 1'b1;
      end
      if (match_b) begin
        pwm_d = 1'b0;
      end
    end
    // stopped in pwm mode returns the pin to its initial level
    if (!count_run_q && pwm_mode_select_q) begin
      pwm_d = PWM_INIT;
    end
    // register writes; a software write to compare b beats the reload
    if (timer_wr) begin
      if (wr_lo && wb_adr_i == OFF_MODE) begin
        count_run_d = wb_dat_i[RUN_BIT];
        phase_count_select_d = wb_dat_i[PHASE_BIT];
        pwm_mode_select_d = wb_dat_i[PWM_BIT];
      end
      if (wr_lo && wb_adr_i == OFF_CNTCTL) begin
        clear_select_d = tpwm_clr_t'(wb_dat_i[CLR_HI:CLR_LO]);
        source_select_d = wb_dat_i[SRC_HI:SRC_LO];
      end
      if (wr_lo && wb_adr_i == OFF_IOCTL) begin
        buffer_b_enable_d = wb_dat_i[BUFB_BIT];
      end
      if ((wr_lo || wr_hi) && wb_adr_i == OFF_CMPA) begin
        compare_a_d = lane16(compare_a_q, wb_dat_i, wb_sel_i);
      end
      if ((wr_lo || wr_hi) && wb_adr_i == OFF_CMPB) begin
        compare_b_d = lane16(compare_b_q, wb_dat_i, wb_sel_i);
      end
      if ((wr_lo || wr_hi) && wb_adr_i == OFF_BUFB) begin
        buffer_b_d = lane16(buffer_b_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (timer_rst) begin
      count_run_q <= 1'b0;
      phase_count_select_q <= 1'b0;
      pwm_mode_select_q <= 1'b0;
      clear_select_q <= TPWM_CLR_NONE;
      source_select_q <= SRC_RST;
      buffer_b_enable_q <= 1'b0;
      compare_a_q <= CMP_RST;
      compare_b_q <= CMP_RST;
      buffer_b_q <= CMP_RST;
      main_counter_q <= CNT_RST;
      pwm_q <= PWM_INIT;
    end else begin
      count_run_q <= count_run_d;
      phase_count_select_q <= phase_count_select_d;
      pwm_mode_select_q <= pwm_mode_select_d;
      clear_select_q <= clear_select_d;
      source_select_q <= source_select_d;
      buffer_b_enable_q <= buffer_b_enable_d;
      compare_a_q <= compare_a_d;
      compare_b_q <= compare_b_d;
      buffer_b_q <= buffer_b_d;
      main_counter_q <= main_counter_d;
      pwm_q <= pwm_d;
    end
  end

  assign pwm_out_pin_o = pwm_q;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_GATE_HOLDS_RESET: assert property (
    !timer_clock_gate_q |=> (main_counter_q == CNT_RST) && !count_run_q && (pwm_q == PWM_INIT))
    else $error("timer not held in reset while gated");

  AST_GATE_BLOCKS_WRITE: assert property (
    (!timer_clock_gate_q && wr_lo && wb_adr_i == OFF_CMPA) |=> compare_a_q == CMP_RST)
    else $error("write accepted while gated");

  AST_GATE_ALLOWS_WRITE: assert property (
    (timer_clock_gate_q && wr_lo && wb_adr_i == OFF_CMPA && wb_sel_i[1:0] == 2'h3)
      |=> compare_a_q == $past(wb_dat_i[CNT_W-1:0]))
    else $error("compare a write lost while clocked");

  AST_STOP_INIT_LEVEL: assert property (
    (!count_run_q && pwm_mode_select_q && timer_clock_gate_q) |=> pwm_out_pin_o == PWM_INIT)
    else $error("pwm pin not at initial level when stopped");

  AST_STOP_HOLDS_COUNT: assert property (
    (!count_run_q && timer_clock_gate_q && !wr) |=> $stable(main_counter_q))
    else $error("counter moved while stopped");

  AST_MASK_BLOCKS: assert property (
    timer_irq_mask_q |-> !timer_irq_o)
    else $error("interrupt passed while masked");

  AST_PEND_SET: assert property (
    match_a |=> timer_irq_pending_q ##0 (timer_irq_o == !timer_irq_mask_q))
    else $error("pending flag not set by match a");

  AST_CLEAR_ON_A: assert property (
    (clear_select_q == TPWM_CLR_A && match_a && timer_clock_gate_q) |=> main_counter_q == CNT_RST)
    else $error("counter not cleared on match a");

  AST_NO_CLEAR: assert property (
    (clear_select_q == TPWM_CLR_NONE && step && timer_clock_gate_q)
      |=> main_counter_q == $past(main_counter_q) + 16'h0001)
    else $error("counter did not step by one");

  AST_PWM_HIGH_A: assert property (
    (pwm_mode_select_q && match_a && !match_b && timer_clock_gate_q) ##1 count_run_q |-> pwm_out_pin_o)
    else $error("pwm pin not high after match a");

  AST_BUFFER_LOAD: assert property (
    (buffer_b_enable_q && match_b && timer_clock_gate_q && !(wr && wb_adr_i == OFF_CMPB))
      |=> compare_b_q == $past(buffer_b_q))
    else $error("compare b not reloaded from buffer");
endmodule
`default_nettype wire

// [verilog/tpwm_pkg.sv]
// register map, field positions, reset values and codes of the pwm timer
package tpwm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int DIV_W = 5;

  // register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFF_GATE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_REQ = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CNTCTL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CMPA = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CMPB = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_BUFB = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_IOCTL = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h24;

  // field positions
  localparam int GATE_BIT = 6;
  localparam int RUN_BIT = 7;
  localparam int PHASE_BIT = 1;
  localparam int PWM_BIT = 0;
  localparam int MASK_BIT = 3;
  localparam int PEND_BIT = 3;
  localparam int CLR_HI = 6;
  localparam int CLR_LO = 5;
  localparam int SRC_HI = 2;
  localparam int SRC_LO = 0;
  localparam int BUFB_BIT = 7;

  // reset values
  localparam logic MASK_RST = 1'b1;
  localparam logic PWM_INIT = 1'b0;
  localparam logic [CNT_W-1:0] CMP_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [2:0] SRC_RST = 3'h0;

  // counter clear sources, in field encoding order
  typedef enum logic [1:0] {TPWM_CLR_NONE, TPWM_CLR_A, TPWM_CLR_B, TPWM_CLR_RSVD} tpwm_clr_t;

  // count source codes
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV8 = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXTA = 3'h5;
  localparam logic [2:0] SRC_RSVD = 3'h6;
  localparam logic [2:0] SRC_EXTB = 3'h7;
endpackage

// [verilog/tpwm_prescale.sv]
// count source selector: system clock divider and synchronised external clocks
`timescale 1ns/1ps
`default_nettype none
module tpwm_prescale (
  input wire logic clk_i,                       // system clock
  input wire logic rst_i,                       // timer reset, sync, high
  input wire logic [2:0] src_sel_i,             // count source code
  input wire logic ext_clock_a_i,               // external clock a pin
  input wire logic ext_clock_b_i,               // external clock b pin
  output logic tick_o                           // one-cycle count tick
);
  import tpwm_pkg::*;

  logic [DIV_W-1:0] div_q, div_d;
  logic [1:0] sa_q, sa_d, sb_q, sb_d;
  logic pa_q, pa_d, pb_q, pb_d;

  // divider and two-flop synchronisers; only the second stage feeds edge logic
  always_comb begin
    div_d = div_q + 5'h01;
    sa_d = {sa_q[0], ext_clock_a_i};
    sb_d = {sb_q[0], ext_clock_b_i};
    pa_d = sa_q[1];
    pb_d = sb_q[1];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 5'h00;
      sa_q <= 2'h0;
      sb_q <= 2'h0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
    end else begin
      div_q <= div_d;
      sa_q <= sa_d;
      sb_q <= sb_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
    end
  end

  // tick select; the reserved code never ticks so the counter holds
  always_comb begin
    unique case (src_sel_i)
      SRC_DIV1: tick_o = 1'b1;
      SRC_DIV2: tick_o = div_q[0];
      SRC_DIV4: tick_o = &div_q[1:0];
      SRC_DIV8: tick_o = &div_q[2:0];
      SRC_DIV32: tick_o = &div_q;
      SRC_EXTA: tick_o = sa_q[1] & ~pa_q;
      SRC_RSVD: tick_o = 1'b0;
      SRC_EXTB: tick_o = sb_q[1] & ~pb_q;
    endcase
  end
endmodule
`default_nettype wire

// [tb/tpwm_load.sv]
// behavioural load on the pwm pin: counts rising edges and high cycles
`timescale 1ns/1ps
`default_nettype none
module tpwm_load (
  input wire logic clk_i,         // system clock
  input wire logic pwm_i,         // pwm level driven into the load
  output logic [31:0] rises_o,    // rising edges seen so far
  output logic [31:0] highs_o     // cycles spent high so far
);
  // a resistive load has no memory, so only running totals are kept
  logic last_q = 1'b0;
  logic [31:0] rises_q = 32'h0;
  logic [31:0] highs_q = 32'h0;

  assign rises_o = rises_q;
  assign highs_o = highs_q;

  // unknown levels count as low so a floating pin never looks like a pulse
  always @(posedge clk_i) begin
    last_q <= (pwm_i === 1'b1);
    if (pwm_i === 1'b1) begin
      highs_q <= highs_q + 32'h1;
      if (!last_q) begin
        rises_q <= rises_q + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tpwm_core_tb.sv]
// self-checking bench for the pwm timer core, driven over wishbone
`timescale 1ns/1ps
`default_nettype none
module tpwm_core_tb;
  import tpwm_pkg::*;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, pwm, irq;
  logic [ADDR_W-1:0] wb_adr;
  logic [3:0] wb_sel;
  logic [DATA_W-1:0] wb_wdat, wb_rdat;
  logic [7:0] ext_q = 8'h00;
  logic [31:0] rises, highs, r, h, c0, c1;
  int bad_count, comparisons;
  int cpt[8] = '{1, 2, 4, 8, 32, 8, 0, 16};
  int clr_code[4] = '{1, 2, 0, 3};
  int clr_high[4] = '{32, 16, 0, 0};

  tpwm_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .ext_clock_a_i(ext_q[2]), .ext_clock_b_i(ext_q[3]), .pwm_out_pin_o(pwm), .timer_irq_o(irq));
  tpwm_load load (.clk_i(clk_i), .pwm_i(pwm), .rises_o(rises), .highs_o(highs));

  // 25 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // external count clocks: a ticks every 8 cycles, b every 16, so a mix-up shows
  always @(posedge clk_i) begin
    ext_q <= ext_q + 8'h01;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled, bounded wait
  task automatic bus(input logic we, input logic [ADDR_W-1:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    wb_sel <= 4'h3;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 16);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (wb_ack !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: bus answer never came", $time);
      complete_run();
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] adr, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, adr, d, unused);
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, adr, 32'h0, d);
    check(d, exp);
  endtask

  // settle one window, then count load activity over a second equal window
  task automatic measure(input int n, output logic [31:0] rr, output logic [31:0] hh);
    logic [31:0] r0, h0;
    repeat (n) @(posedge clk_i);
    r0 = rises;
    h0 = highs;
    repeat (n) @(posedge clk_i);
    rr = rises - r0;
    hh = highs - h0;
  endtask

  initial begin
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place, writes refused while gated
    rdchk(OFF_MASK, 32'(MASK_RST) << MASK_BIT);
    rdchk(OFF_REQ, 32'h0);
    rdchk(8'h40, 32'h0);
    wr(OFF_CMPA, 32'h0003);
    rdchk(OFF_CMPA, 32'(CMP_RST));
    check({31'h0, pwm}, {31'h0, PWM_INIT});
    $display("test reset and gate done");
    // pwm with period 4 ticks, low after count 1
    wr(OFF_GATE, 32'h1 << GATE_BIT);
    rdchk(OFF_GATE, 32'h1 << GATE_BIT);
    wr(OFF_CMPA, 32'h1234_0003);
    rdchk(OFF_CMPA, 32'h0003);
    wr(OFF_CMPB, 32'h0001);
    wr(OFF_CNTCTL, 32'h20);
    wr(OFF_MODE, 32'h81);
    measure(40, r, h);
    check(r, 32'd10);
    check(h, 32'd20);
    $display("test pwm waveform done");
    // pending flag, mask, stop and clear
    rdchk(OFF_REQ, 32'h8);
    check({31'h0, irq}, 32'h0);
    wr(OFF_MASK, 32'h0);
    @(posedge clk_i);
    check({31'h0, irq}, 32'h1);
    wr(OFF_MODE, 32'h01);
    repeat (2) @(posedge clk_i);
    check({31'h0, pwm}, {31'h0, PWM_INIT});
    bus(1'b0, OFF_COUNT, 32'h0, c0);
    bus(1'b0, OFF_COUNT, 32'h0, c1);
    check(c1, c0);
    check({31'h0, c0 <= 32'h3}, 32'h1);
    wr(OFF_REQ, 32'h0);
    rdchk(OFF_REQ, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(OFF_MASK, 32'h8);
    $display("test interrupt flag done");
    // every clear select code with b above a
    wr(OFF_CMPB, 32'h0007);
    wr(OFF_MODE, 32'h81);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CNTCTL, 32'(clr_code[i]) << CLR_LO);
      measure(32, r, h);
      check(h, 32'(clr_high[i]));
    end
    wr(OFF_GATE, 32'h0);
    rdchk(OFF_CMPA, 32'(CMP_RST));
    check({31'h0, pwm}, {31'h0, PWM_INIT});
    $display("test clear select done");
    // every count source, four periods of 8 ticks each
    wr(OFF_GATE, 32'h1 << GATE_BIT);
    wr(OFF_CMPA, 32'h0007);
    wr(OFF_CMPB, 32'h0003);
    wr(OFF_MODE, 32'h81);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_CNTCTL, 32'h20 | 32'(i));
      measure(32 * ((cpt[i] == 0) ? 8 : cpt[i]), r, h);
      check(r, (cpt[i] == 0) ? 32'd0 : 32'd4);
    end
    $display("test count sources done");
    // buffered change point: b drops from 3 to 1 at the next match b
    // buffer loaded before enabling, so a match b never pulls in the reset value
    wr(OFF_CNTCTL, 32'h20);
    wr(OFF_BUFB, 32'h0001);
    wr(OFF_IOCTL, 32'h80);
    measure(32, r, h);
    check(h, 32'd8);
    rdchk(OFF_CMPB, 32'h0001);
    // phase select holds the counter; timer mode leaves the pin alone
    wr(OFF_MODE, 32'h83);
    bus(1'b0, OFF_COUNT, 32'h0, c0);
    bus(1'b0, OFF_COUNT, 32'h0, c1);
    check(c1, c0);
    wr(OFF_MODE, 32'h80);
    measure(32, r, h);
    check(r, 32'd0);
    $display("test buffer and modes done");
    complete_run();
  end
endmodule
`default_nettype wire
